// file: hdl/dlsr_ctrl.sv
// Converter control: latch gating, supply events, reset delay and serial slave front.
// Assumes an Avalon-MM master on mclk and asynchronous pins on every other input.
// Function
// R01: Reference pin input, output, or detached
// R02: Even channels use first reference pin
// R03: Gain applies only for pin or bandgap
// R04: Power-down field selects pull-down per channel
// R05: Latch high holds governed outputs
// R06: Latch low copies values to outputs
// R07: Latch low passes writes at once
// R08: Even latch even channels, odd latch odd
// R09: User config writes need high-voltage entry
// R10: Serial port is slave only
// R11: Sample on rising, drive after falling
// R12: Data changes only while clock low
// R13: Straps set two low address bits
// R14: Rising supply is power-on, falling brown-out
// R15: Power-on copies nonvolatile into volatile
// R16: Power-on sets status flag
// R17: Reject serial commands until delay expires
// R18: Power-on clears memory pointer
// R19: Brown-out disables serial and nonvolatile writes
// R20: Brown-out forces power-down, analog off
// R21: Brown-out clears codes, reference, gain
// R22: Operation continues below full-spec supply
// R23: Latch pins synchronised before use
// R24: Reset delay counter holds serial reset
`timescale 1ns/1ps
`default_nettype none
module dlsr_ctrl #(
    parameter int RESET_DELAY_CYC = dlsr_pkg::RESET_DELAY_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [6:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic even_channel_update_strobe_n,
    input wire logic odd_channel_update_strobe_n,
    input wire logic high_voltage_program_entry,
    input wire logic supply_above_trip,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic slave_addr_strap_high,
    input wire logic slave_addr_strap_low,
    output dlsr_pkg::dlsr_chan_type [dlsr_pkg::NUM_CHAN-1:0] channel_analog_output,
    output logic [1:0] even_group_reference_pin,
    output logic [1:0] odd_group_reference_pin,
    output logic analog_enable
);
    dlsr_pkg::dlsr_state_type s_q;
    dlsr_pkg::dlsr_state_type s_d;
    dlsr_pkg::dlsr_pins_type pins_raw;
    dlsr_pkg::dlsr_pins_type pin;
    logic por_ev;
    logic bor_ev;
    logic wr_go;
    logic scl_rise;
    logic scl_fall;
    logic [6:0] my_addr;
    logic [7:0] shifted;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    assign pins_raw = '{even_strobe_n: even_channel_update_strobe_n,
                        odd_strobe_n: odd_channel_update_strobe_n,
                        hv_entry: high_voltage_program_entry,
                        supply_ok: supply_above_trip,
                        scl: scl_in,
                        sda: sda_in,
                        strap_high: slave_addr_strap_high,
                        strap_low: slave_addr_strap_low};

    // R23 latch pins synchronised
    dlsr_sync #(
        .WIDTH($bits(dlsr_pkg::dlsr_pins_type))
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(pins_raw),
        .dout(pin)
    );

    // ------------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------------
    function automatic logic [31:0] rd_word(input dlsr_pkg::dlsr_state_type s,
                                            input logic [6:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a >= dlsr_pkg::OFS_VOL_CODE && a < dlsr_pkg::OFS_NV_CODE) begin
            w[dlsr_pkg::CODE_W-1:0] = s.vol_code[a[4:2]];
        end else if (a >= dlsr_pkg::OFS_NV_CODE && a < dlsr_pkg::OFS_VOL_REF) begin
            w[dlsr_pkg::CODE_W-1:0] = s.nv_code[a[4:2]];
        end else begin
            unique case (a)
                dlsr_pkg::OFS_VOL_REF: w[15:0] = s.vol_ref;
                dlsr_pkg::OFS_VOL_PD: w[15:0] = s.vol_pd;
                dlsr_pkg::OFS_VOL_GAIN: w[7:0] = s.vol_gain;
                dlsr_pkg::OFS_NV_REF: w[15:0] = s.nv_ref;
                dlsr_pkg::OFS_NV_PD: w[15:0] = s.nv_pd;
                dlsr_pkg::OFS_NV_GAIN: w[7:0] = s.nv_gain;
                dlsr_pkg::OFS_NV_ADDR: w[6:0] = s.nv_addr;
                dlsr_pkg::OFS_STATUS: begin
                    w[dlsr_pkg::ST_POR_BIT] = s.por_flag;
                    w[dlsr_pkg::ST_READY_BIT] = s.ready;
                    w[dlsr_pkg::ST_BROWN_BIT] = ~s.sup_prev;
                    w[dlsr_pkg::ST_ANALOG_BIT] = s.analog_en;
                    w[dlsr_pkg::ST_REFUSED_BIT] = s.nv_refused;
                    w[dlsr_pkg::ST_MATCH_LSB +: 8] = s.match_cnt;
                end
                dlsr_pkg::OFS_POINTER: w[4:0] = s.pointer;
                default: w = 32'h0000_0000;
            endcase
        end
        return w;
    endfunction : rd_word

    // ------------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------------
    // R14 rising is power-on, falling brown-out
    assign por_ev = pin.supply_ok & ~s_q.sup_prev;
    assign bor_ev = ~pin.supply_ok & s_q.sup_prev;
    // Write lands at the edge where the master sees waitrequest low
    assign wr_go = avs_write & ~s_q.av_wait;
    // R11 edges found on synchronised serial clock
    assign scl_rise = pin.scl & ~s_q.scl_prev;
    assign scl_fall = ~pin.scl & s_q.scl_prev;
    // R13 straps give the two low address bits
    assign my_addr = {s_q.nv_addr[6:2], pin.strap_high, pin.strap_low};
    assign shifted = {s_q.shift[6:0], pin.sda};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.sup_prev = pin.supply_ok;
        s_d.scl_prev = pin.scl;
        s_d.sda_prev = pin.sda;

        // Bus slave: one wait cycle, then a single-cycle answer
        s_d.av_wait = 1'b1;
        if ((avs_read | avs_write) && s_q.av_wait) begin
            s_d.av_wait = 1'b0;
            s_d.rdata = rd_word(s_q, avs_address);
        end

        // R22 nothing gates on the full-spec level, only on the trip level
        if (wr_go) begin
            if (avs_address < dlsr_pkg::OFS_NV_CODE) begin
                s_d.vol_code[avs_address[4:2]] = avs_writedata[dlsr_pkg::CODE_W-1:0];
            end
            unique case (avs_address)
                dlsr_pkg::OFS_VOL_REF: s_d.vol_ref = avs_writedata[15:0];
                dlsr_pkg::OFS_VOL_PD: s_d.vol_pd = avs_writedata[15:0];
                dlsr_pkg::OFS_VOL_GAIN: s_d.vol_gain = avs_writedata[7:0];
                dlsr_pkg::OFS_POINTER: s_d.pointer = avs_writedata[4:0];
                dlsr_pkg::OFS_STATUS: begin
                    if (avs_writedata[dlsr_pkg::ST_POR_BIT]) begin
                        s_d.por_flag = 1'b0;
                    end
                    if (avs_writedata[dlsr_pkg::ST_REFUSED_BIT]) begin
                        s_d.nv_refused = 1'b0;
                    end
                end
                default: begin
                end
            endcase
            // R19 nonvolatile writes blocked while browned out
            if (s_q.sup_prev) begin
                if (avs_address >= dlsr_pkg::OFS_NV_CODE
                        && avs_address < dlsr_pkg::OFS_VOL_REF) begin
                    s_d.nv_code[avs_address[4:2]] = avs_writedata[dlsr_pkg::CODE_W-1:0];
                end
                unique case (avs_address)
                    dlsr_pkg::OFS_NV_REF: s_d.nv_ref = avs_writedata[15:0];
                    dlsr_pkg::OFS_NV_PD: s_d.nv_pd = avs_writedata[15:0];
                    dlsr_pkg::OFS_NV_GAIN: s_d.nv_gain = avs_writedata[7:0];
                    default: begin
                    end
                endcase
            end
            // R09 user config needs high-voltage entry
            if (avs_address == dlsr_pkg::OFS_NV_ADDR) begin
                if (s_q.sup_prev && pin.hv_entry) begin
                    s_d.nv_addr = avs_writedata[6:0];
                end else begin
                    s_d.nv_refused = 1'b1;
                end
            end
            if (!s_q.sup_prev && avs_address >= dlsr_pkg::OFS_NV_CODE
                    && avs_address <= dlsr_pkg::OFS_NV_GAIN
                    && avs_address != dlsr_pkg::OFS_VOL_REF
                    && avs_address != dlsr_pkg::OFS_VOL_PD
                    && avs_address != dlsr_pkg::OFS_VOL_GAIN) begin
                s_d.nv_refused = 1'b1;
            end
        end

        // R24 reset delay counter
        if (s_q.sup_prev && !s_q.ready) begin
            s_d.tmr = s_q.tmr + 16'h0001;
            if (s_q.tmr == 16'(RESET_DELAY_CYC - 1)) begin
                s_d.ready = 1'b1;
            end
        end

        if (por_ev) begin
            // R15 recall nonvolatile settings
            s_d.vol_code = s_q.nv_code;
            s_d.vol_ref = s_q.nv_ref;
            s_d.vol_pd = s_q.nv_pd;
            s_d.vol_gain = s_q.nv_gain;
            // R16 power-on flag, set wins over clear
            s_d.por_flag = 1'b1;
            // R17 restart delay, serial held off
            s_d.tmr = 16'h0000;
            s_d.ready = 1'b0;
            // R18 pointer to first location
            s_d.pointer = 5'h00;
            s_d.analog_en = 1'b1;
        end
        if (!pin.supply_ok) begin
            // R19 serial disabled
            s_d.ready = 1'b0;
            s_d.tmr = 16'h0000;
            // R20 all power-down, analog off
            s_d.vol_pd = '1;
            s_d.analog_en = 1'b0;
            // R21 codes, reference and gain cleared
            s_d.vol_code = '0;
            s_d.vol_ref = '0;
            s_d.vol_gain = '0;
        end

        for (int i = 0; i < dlsr_pkg::NUM_CHAN; i++) begin
            // R08 even strobe even channels, odd strobe odd
            // R05 strobe high holds; R06 R07 strobe low passes through
            if (((i % 2 == 0) ? ~pin.even_strobe_n : ~pin.odd_strobe_n)
                    || !pin.supply_ok) begin
                s_d.out[i].code = s_d.vol_code[i];
                s_d.out[i].ref_sel = s_d.vol_ref[i];
                // R04 power-down field picks the pull-down
                s_d.out[i].pd_sel = s_d.vol_pd[i];
                // R03 gain only with pin or bandgap reference
                s_d.out[i].gain = s_d.vol_gain[i]
                                  & (s_d.vol_ref[i] != dlsr_pkg::REF_SUPPLY);
            end
        end
        // R01 R02 bit1 senses pin input, bit0 drives bandgap out; both low detaches
        s_d.even_ref = {s_d.out[0].ref_sel[1], s_d.out[0].ref_sel == dlsr_pkg::REF_BANDGAP};
        s_d.odd_ref = {s_d.out[1].ref_sel[1], s_d.out[1].ref_sel == dlsr_pkg::REF_BANDGAP};

        // Serial front end; R10 no clock output exists
        if (!s_q.ready) begin
            // R17 commands rejected while held in reset
            s_d.ser = dlsr_pkg::SER_IDLE;
            s_d.sda_oe = 1'b0;
        end else if (pin.scl && s_q.scl_prev && s_q.sda_prev && !pin.sda) begin
            s_d.ser = dlsr_pkg::SER_ADDR;
            s_d.bitcnt = 3'h0;
            s_d.sda_oe = 1'b0;
        end else if (pin.scl && s_q.scl_prev && !s_q.sda_prev && pin.sda) begin
            s_d.ser = dlsr_pkg::SER_IDLE;
            s_d.sda_oe = 1'b0;
        end else begin
            unique case (s_q.ser)
                dlsr_pkg::SER_IDLE: begin
                end
                dlsr_pkg::SER_ADDR: begin
                    // R11 sample on rising edge
                    if (scl_rise) begin
                        s_d.shift = shifted;
                        s_d.bitcnt = s_q.bitcnt + 3'h1;
                        if (s_q.bitcnt == 3'h7) begin
                            s_d.ser = (shifted[7:1] == my_addr) ? dlsr_pkg::SER_ACK
                                                                : dlsr_pkg::SER_SKIP;
                            if (shifted[7:1] == my_addr) begin
                                s_d.match_cnt = s_q.match_cnt + 8'h01;
                            end
                        end
                    end
                end
                dlsr_pkg::SER_ACK: begin
                    // R12 drive changes only after a falling edge
                    if (scl_fall) begin
                        s_d.sda_oe = ~s_q.sda_oe;
                        if (s_q.sda_oe) begin
                            s_d.ser = dlsr_pkg::SER_SKIP;
                        end
                    end
                end
                dlsr_pkg::SER_SKIP: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.av_wait <= 1'b1;
            s_q.nv_code <= {{(dlsr_pkg::NUM_CHAN - 2){dlsr_pkg::NV_CODE_FULL}},
                            dlsr_pkg::NV_CODE_MID, dlsr_pkg::NV_CODE_MID};
            s_q.nv_addr <= dlsr_pkg::NV_ADDR_RESET;
            s_q.vol_pd <= '1;
            for (int i = 0; i < dlsr_pkg::NUM_CHAN; i++) begin
                s_q.out[i].pd_sel <= dlsr_pkg::PD_OPEN;
            end
            s_q.ser <= dlsr_pkg::SER_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_waitrequest = s_q.av_wait;
    assign avs_readdata = s_q.rdata;
    assign sda_out = 1'b0;
    assign sda_oe = s_q.sda_oe;
    assign channel_analog_output = s_q.out;
    assign even_group_reference_pin = s_q.even_ref;
    assign odd_group_reference_pin = s_q.odd_ref;
    assign analog_enable = s_q.analog_en;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence power_up_s;
        por_ev ##1 !s_q.ready;
    endsequence

    bus_answer_a: assert property ((avs_read | avs_write) && avs_waitrequest
                                   |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");
    // R15 recall
    nv_recall_a: assert property (por_ev |=> s_q.vol_code == $past(s_q.nv_code)) // R15
        else $error("power-on did not recall codes");
    // R16 flag
    por_flag_a: assert property (por_ev |=> s_q.por_flag) // R16
        else $error("power-on flag not set");
    // R17 delay
    delay_gate_a: assert property (power_up_s |-> ##1 (!s_q.ready && !sda_oe) [*4]) // R17
        else $error("serial active during reset delay");
    // R18 pointer
    ptr_clear_a: assert property (por_ev |=> s_q.pointer == 5'h00) // R18
        else $error("pointer not cleared on power-on");
    // R20 R21 brown-out outputs
    brown_force_a: assert property (bor_ev |=> !analog_enable
                                    && channel_analog_output[0].pd_sel == dlsr_pkg::PD_OPEN
                                    && channel_analog_output[1].code == '0) // R20
        else $error("brown-out did not force outputs");
    // R05 hold
    latch_hold_a: assert property (pin.even_strobe_n && pin.supply_ok
                                   |=> $stable(channel_analog_output[0])) // R05
        else $error("even output moved while strobe high");
    // R07 pass-through
    latch_pass_a: assert property (!pin.odd_strobe_n && pin.supply_ok
                                   |=> channel_analog_output[1].code == s_q.vol_code[1]) // R07
        else $error("odd output not following code");
    // R11 drive timing
    sda_edge_a: assert property ($rose(sda_oe) |-> $past(scl_fall)) // R11
        else $error("data driven outside falling edge");
    // R09 refusal
    hv_refuse_a: assert property (wr_go && avs_address == dlsr_pkg::OFS_NV_ADDR
                                  && !pin.hv_entry |=> $stable(s_q.nv_addr)) // R09
        else $error("user config written without high voltage");
    // R03 gain mask
    gain_mask_a: assert property (channel_analog_output[0].ref_sel == dlsr_pkg::REF_SUPPLY
                                  |-> !channel_analog_output[0].gain) // R03
        else $error("gain applied with supply reference");
endmodule : dlsr_ctrl
`default_nettype wire

// file: hdl/dlsr_pkg.sv
// Constants, register map and carrier types of the converter control block.
// Assumes a single 125 MHz system clock and a byte-addressed register bus.
package dlsr_pkg;

    // ------------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------------
    localparam int NUM_CHAN = 8;
    localparam int CODE_W = 12;
    localparam int CLK_PERIOD_NS = 8;
    localparam int RESET_DELAY_NS = 1000;
    // Least time, so round up
    localparam int RESET_DELAY_CYC = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [6:0] OFS_VOL_CODE = 7'h00;
    localparam logic [6:0] OFS_NV_CODE = 7'h20;
    localparam logic [6:0] OFS_VOL_REF = 7'h40;
    localparam logic [6:0] OFS_VOL_PD = 7'h44;
    localparam logic [6:0] OFS_VOL_GAIN = 7'h48;
    localparam logic [6:0] OFS_NV_REF = 7'h4C;
    localparam logic [6:0] OFS_NV_PD = 7'h50;
    localparam logic [6:0] OFS_NV_GAIN = 7'h54;
    localparam logic [6:0] OFS_NV_ADDR = 7'h58;
    localparam logic [6:0] OFS_STATUS = 7'h5C;
    localparam logic [6:0] OFS_POINTER = 7'h60;

    // ------------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------------
    localparam int ST_POR_BIT = 0;
    localparam int ST_READY_BIT = 1;
    localparam int ST_BROWN_BIT = 2;
    localparam int ST_ANALOG_BIT = 3;
    localparam int ST_REFUSED_BIT = 4;
    localparam int ST_MATCH_LSB = 8;

    // ------------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] REF_SUPPLY = 2'h0;
    localparam logic [1:0] REF_BANDGAP = 2'h1;
    localparam logic [1:0] REF_PIN_UNBUF = 2'h2;
    localparam logic [1:0] REF_PIN_BUF = 2'h3;
    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [1:0] PD_LOW_RES_1K = 2'h1;
    localparam logic [1:0] PD_HIGH_RES_125K = 2'h2;
    localparam logic [1:0] PD_OPEN = 2'h3;
    localparam logic [CODE_W-1:0] NV_CODE_MID = 12'h7FF;
    localparam logic [CODE_W-1:0] NV_CODE_FULL = 12'hFFF;
    localparam logic [6:0] NV_ADDR_RESET = 7'h60;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic [1:0] ref_sel;
        logic [1:0] pd_sel;
        logic gain;
    } dlsr_chan_type;

    typedef struct packed {
        logic even_strobe_n;
        logic odd_strobe_n;
        logic hv_entry;
        logic supply_ok;
        logic scl;
        logic sda;
        logic strap_high;
        logic strap_low;
    } dlsr_pins_type;

    typedef enum logic [1:0] {SER_IDLE, SER_ADDR, SER_ACK, SER_SKIP} dlsr_ser_type;

    typedef struct packed {
        logic av_wait;
        logic [31:0] rdata;
        logic sup_prev;
        logic [NUM_CHAN-1:0][CODE_W-1:0] vol_code;
        logic [NUM_CHAN-1:0][CODE_W-1:0] nv_code;
        logic [NUM_CHAN-1:0][1:0] vol_ref;
        logic [NUM_CHAN-1:0][1:0] vol_pd;
        logic [NUM_CHAN-1:0] vol_gain;
        logic [NUM_CHAN-1:0][1:0] nv_ref;
        logic [NUM_CHAN-1:0][1:0] nv_pd;
        logic [NUM_CHAN-1:0] nv_gain;
        logic [6:0] nv_addr;
        logic por_flag;
        logic nv_refused;
        logic ready;
        logic analog_en;
        logic [15:0] tmr;
        logic [4:0] pointer;
        logic [7:0] match_cnt;
        dlsr_chan_type [NUM_CHAN-1:0] out;
        logic [1:0] even_ref;
        logic [1:0] odd_ref;
        dlsr_ser_type ser;
        logic [2:0] bitcnt;
        logic [7:0] shift;
        logic scl_prev;
        logic sda_prev;
        logic sda_oe;
    } dlsr_state_type;

endpackage : dlsr_pkg

// file: hdl/dlsr_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes inputs come from outside the mclk domain.
`timescale 1ns/1ps
`default_nettype none
module dlsr_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } dlsr_sync_state_type;

    dlsr_sync_state_type s_q;
    dlsr_sync_state_type s_d;

    // First stage feeds only the second stage
    always_comb begin
        s_d.meta = din;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.stable;
endmodule : dlsr_sync
`default_nettype wire

// file: testbench/dac_latch_and_supply_reset_control_tb_top.sv
// Self-checking bench for the converter control block.
// Assumes the design package and modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dac_latch_and_supply_reset_control_tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [6:0] adr = 7'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdat;
    logic wait_r, s_ev = 1'b1, s_od = 1'b1, hv = 1'b0, sup = 1'b0, scl, sda, oe, ack, an;
    logic [31:0] q;
    logic [1:0] rp0, rp1;
    logic st_lo = 1'b0;
    dlsr_pkg::dlsr_chan_type [dlsr_pkg::NUM_CHAN-1:0] outs;
    int err_count = 0;
    int checked = 0;
    always #4 mclk = !mclk;
    dlsr_ctrl #(.RESET_DELAY_CYC(200)) i_dlsr_ctrl (.mclk(mclk), .rst_n(rst_n),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_readdata(rdat), .avs_waitrequest(wait_r),
        .even_channel_update_strobe_n(s_ev), .odd_channel_update_strobe_n(s_od),
        .high_voltage_program_entry(hv), .supply_above_trip(sup), .scl_in(scl),
        .sda_in(sda), .sda_out(), .sda_oe(oe), .slave_addr_strap_high(1'b1),
        .slave_addr_strap_low(st_lo), .channel_analog_output(outs),
        .even_group_reference_pin(rp0), .odd_group_reference_pin(rp1), .analog_enable(an));
    dlsr_host i_host (.mclk(mclk), .sda_oe(oe), .scl(scl), .sda(sda));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Holds the request until waitrequest is seen low; only the watchdog ends a hang
    task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do begin
            @(posedge mclk);
        end while (wait_r !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge mclk);
    endtask : bus
    task automatic s_power();
        sup <= 1'b1;
        repeat (8) @(posedge mclk);
        i_host.frame(8'hC4, ack);
        chk({31'h0, ack}, 32'h0000_0000);
        repeat (250) @(posedge mclk);
        bus(1'b0, dlsr_pkg::OFS_STATUS, 32'h0);
        chk({31'h0, q[dlsr_pkg::ST_POR_BIT]}, 32'h0000_0001);
        bus(1'b0, dlsr_pkg::OFS_POINTER, 32'h0);
        chk(q, 32'h0000_0000);
        bus(1'b0, dlsr_pkg::OFS_VOL_CODE, 32'h0);
        chk(q, 32'h0000_07FF);
        chk({20'h0, outs[0].code}, 32'h0000_0000);
        s_ev <= 1'b0;
        repeat (8) @(posedge mclk);
        chk({20'h0, outs[0].code}, 32'h0000_07FF);
        chk({20'h0, outs[1].code}, 32'h0000_0000);
        bus(1'b1, dlsr_pkg::OFS_VOL_CODE, 32'h0000_0123);
        chk({20'h0, outs[0].code}, 32'h0000_0123);
        bus(1'b1, dlsr_pkg::OFS_VOL_REF, 32'h0000_0009);
        chk({28'h0, rp0, rp1}, 32'h0000_0004);
        bus(1'b1, dlsr_pkg::OFS_VOL_GAIN, 32'h0000_0001);
        bus(1'b1, dlsr_pkg::OFS_VOL_REF, 32'h0000_0002);
        chk({29'h0, outs[0].gain, rp0}, 32'h0000_0006);
        bus(1'b1, dlsr_pkg::OFS_VOL_REF, 32'h0000_0000);
        chk({29'h0, outs[0].gain, rp0}, 32'h0000_0000);
        s_ev <= 1'b1;
        repeat (8) @(posedge mclk);
        bus(1'b1, dlsr_pkg::OFS_VOL_CODE, 32'h0000_0456);
        chk({20'h0, outs[0].code}, 32'h0000_0123);
    endtask : s_power
    task automatic s_serial();
        i_host.frame(8'hC4, ack);
        chk({31'h0, ack}, 32'h0000_0001);
        i_host.frame(8'hC6, ack);
        chk({31'h0, ack}, 32'h0000_0000);
        st_lo <= 1'b1;
        repeat (4) @(posedge mclk);
        i_host.frame(8'hC6, ack);
        chk({31'h0, ack}, 32'h0000_0001);
        bus(1'b0, dlsr_pkg::OFS_STATUS, 32'h0);
        chk({24'h0, q[dlsr_pkg::ST_MATCH_LSB +: 8]}, 32'h0000_0002);
    endtask : s_serial
    task automatic s_brown();
        bus(1'b1, dlsr_pkg::OFS_NV_ADDR, 32'h0000_0010);
        hv <= 1'b1;
        repeat (4) @(posedge mclk);
        bus(1'b1, dlsr_pkg::OFS_NV_ADDR, 32'h0000_0011);
        bus(1'b0, dlsr_pkg::OFS_NV_ADDR, 32'h0);
        chk(q, 32'h0000_0011);
        bus(1'b1, dlsr_pkg::OFS_STATUS, 32'h0000_0010);
        sup <= 1'b0;
        repeat (10) @(posedge mclk);
        chk({outs[0].code, outs[0].pd_sel, an}, 32'h0000_0006);
        bus(1'b1, dlsr_pkg::OFS_NV_CODE, 32'h0000_0111);
        bus(1'b0, dlsr_pkg::OFS_STATUS, 32'h0);
        chk({31'h0, q[dlsr_pkg::ST_REFUSED_BIT]}, 32'h0000_0001);
        bus(1'b0, dlsr_pkg::OFS_NV_CODE, 32'h0);
        chk(q, 32'h0000_07FF);
        bus(1'b1, dlsr_pkg::OFS_POINTER, 32'h0000_0005);
        sup <= 1'b1;
        repeat (8) @(posedge mclk);
        bus(1'b0, dlsr_pkg::OFS_POINTER, 32'h0);
        chk(q, 32'h0000_0000);
        chk({31'h0, an}, 32'h0000_0001);
    endtask : s_brown
    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        s_power();
        s_serial();
        s_brown();
        wrap_up();
    end
    initial begin
        #400000;
        err_count++;
        wrap_up();
    end
endmodule : dac_latch_and_supply_reset_control_tb_top
`default_nettype wire

// file: testbench/dlsr_host.sv
// Serial bus master model driving the two-wire link.
// Assumes the sda wire has a pull-up and either party may pull it low.
`timescale 1ns/1ps
`default_nettype none
module dlsr_host (
    input wire logic mclk,
    input wire logic sda_oe,
    output logic scl,
    output wire logic sda
);
    logic drv_low;
    assign sda = !(drv_low || sda_oe);
    initial begin
        scl = 1'b1;
        drv_low = 1'b0;
    end
    // master clocks at 125 ns, data moves mid-way through scl low
    task automatic frame(input logic [7:0] b, output logic ack);
        int i;
        drv_low <= 1'b1;
        #62.5;
        for (i = 0; i < 9; i++) begin
            scl <= 1'b0;
            #31.25;
            drv_low <= (i < 8) ? !b[7-i] : 1'b0;
            #31.25;
            scl <= 1'b1;
            #62.5;
            ack = !sda;
        end
        scl <= 1'b0;
        #31.25;
        drv_low <= 1'b1;
        #31.25;
        scl <= 1'b1;
        #31.25;
        drv_low <= 1'b0;
        #62.5;
        // Hand back on a clock edge so the register bus can follow at once
        @(posedge mclk);
    endtask : frame
endmodule : dlsr_host
`default_nettype wire
